/* File: rtl/sensor_port_pkg.sv */
/*
 * Shared constants and types for the sensor result output port:
 * output routing codes, status codes, saturation value, bus rates and state.
 * Assumes a single 20 MHz system clock; bus pins arrive asynchronously.
 */
package sensor_port_pkg;

   // output route select codes
   localparam logic [2:0]  SEL_I2C       = 3'h1;
   localparam logic [2:0]  SEL_SPI       = 3'h3;
   localparam logic [2:0]  SEL_CAP       = 3'h4;
   localparam logic [2:0]  SEL_CAPTEMP   = 3'h6;
   // address lock code and factory configuration
   localparam logic [2:0]  LOCK_ON       = 3'h3;
   localparam logic [6:0]  FACTORY_ADDR  = 7'h28;
   localparam logic [2:0]  FACTORY_LOCK  = LOCK_ON;
   // status codes in the top two packet bits
   localparam logic [1:0]  ST_FRESH      = 2'h0;
   localparam logic [1:0]  ST_STALE      = 2'h1;
   localparam logic [1:0]  ST_CMD        = 2'h2;
   localparam logic [13:0] DIAG_SAT      = 14'h3fff;
   localparam logic [1:0]  PAD_BITS      = 2'h0;
   // bit counters
   localparam logic [2:0]  BYTE_LAST     = 3'h7;
   localparam logic [5:0]  SPI_ONE_BYTE  = 6'h08;
   // bus rates, in hertz
   localparam int          SYS_HZ        = 20_000_000;
   localparam int          I2C_STD_HZ    = 100_000;
   localparam int          I2C_FAST_HZ   = 400_000;
   localparam int          I2C_CAL_HZ    = 20_000;
   localparam int          SPI_MAX_HZ    = 800_000;
   // system cycles in the shortest half period of each bus clock
   localparam int          I2C_HALF_CYC  = SYS_HZ / (2 * I2C_FAST_HZ);
   localparam int          SPI_HALF_CYC  = SYS_HZ / (2 * SPI_MAX_HZ);

   typedef enum logic [6:0] {
      I_IDLE = 7'h01,
      I_ADDR = 7'h02,
      I_AACK = 7'h04,
      I_TX   = 7'h08,
      I_MACK = 7'h10,
      I_RX   = 7'h20,
      I_RACK = 7'h40
   } i2c_state_t;

   typedef struct packed {
      logic [13:0] cap;
      logic [13:0] temp;
   } result_t;

   typedef struct packed {
      logic [2:0]  scl_sync;
      logic [2:0]  sda_sync;
      logic [2:0]  ss_sync;
      i2c_state_t  ist;
      logic [2:0]  bit_cnt;
      logic [7:0]  rx_byte;
      logic [31:0] tx_shift;
      logic        rd_xfer;
      logic        mack_ok;
      logic        rx_armed;
      logic [5:0]  spi_bits;
      logic        spi_seen;
      logic        fresh;
      logic [6:0]  addr_reg;
      logic [2:0]  lock_reg;
      logic        sda_out;
      logic        sda_oe;
      logic        miso_out;
      logic        miso_oe;
      logic        ready_pin;
      logic        alarm_low_pin;
      logic        measure_req;
      logic [7:0]  cal_byte;
      logic        cal_strobe;
      logic        fetch_done;
   } state_t;

endpackage : sensor_port_pkg

/* File: rtl/sensor_result_output_port.sv */
/*
 * Result output port: pin routing by output select, I2C slave and
 * read-only SPI slave serving the 4-byte result packet.
 * Assumes scl, sda and ss_n come from pins (asynchronous, synchronised here),
 * bus clocks well below clk_sys/8, and result inputs stable on clk_sys.
 */
import sensor_port_pkg::*;

// Contract
// - route select enables I2C, SPI or density outputs
// - density streams take ready and low alarm pins
// - I2C slave runs at 100 and 400 kHz
// - answer own address only when lock engaged
// - shipped address 28 hex with lock engaged
// - SPI read only, clock up to 800 kHz
// - MISO changes on falling edge, swappable
// - either SPI clock idle level works unchanged
// - fetch, measure request, calibration by bus/mode
// - packet captured at transfer start, held throughout
// - results fourteen bits, most significant first
// - I2C fetch is address plus read, acknowledged
// - bytes keep coming until master NACK and stop
// - status bits top, capacitance fills two bytes
// - temperature in bytes three and four, padded
// - SPI packet 32 bits in fixed order
// - status codes fresh, stale, command mode
// - diagnostic error reports saturated 3fff values
module sensor_result_output_port (
   input  wire logic                      clk_sys,
   input  wire logic                      arst_n,
   input  wire logic [2:0]                output_sel,
   input  wire logic [6:0]                slave_address_field,
   input  wire logic [2:0]                addr_lock_field,
   input  wire logic                      cfg_load,
   input  wire logic                      spi_sample_edge,
   input  wire logic                      sleep_mode,
   input  wire logic                      command_mode,
   input  wire logic                      diag_error,
   input  wire sensor_port_pkg::result_t  result,
   input  wire logic                      result_valid,
   input  wire logic                      ready_in,
   input  wire logic                      alarm_low_in,
   input  wire logic                      cap_density_out,
   input  wire logic                      temp_density_out,
   input  wire logic                      scl_in,
   input  wire logic                      sda_in,
   output logic                           sda_out,
   output logic                           sda_oe,
   input  wire logic                      ss_n_in,
   output logic                           miso_out,
   output logic                           miso_oe,
   output logic                           ready_pin,
   output logic                           alarm_low_pin,
   output logic                           measure_req,
   output logic [7:0]                     cal_byte,
   output logic                           cal_strobe,
   output logic                           fetch_done
);
   import sensor_port_pkg::*;

   state_t      s_reg;
   state_t      s_next;
   logic        scl_rise;
   logic        scl_fall;
   logic        sda_now;
   logic        i2c_start;
   logic        i2c_stop;
   logic        ss_fall;
   logic        ss_rise;
   logic        sclk_rise;
   logic        sclk_fall;
   logic        i2c_on;
   logic        spi_on;
   logic        addr_hit;
   logic [1:0]  status;
   logic [13:0] cap_v;
   logic [13:0] temp_v;
   logic [31:0] packet;

   // edges seen on the second and third sampler stages only
   assign scl_rise  = s_reg.scl_sync[1] & ~s_reg.scl_sync[2];
   assign scl_fall  = ~s_reg.scl_sync[1] & s_reg.scl_sync[2];
   assign sda_now   = s_reg.sda_sync[1];
   // start and stop need scl high on two samples, so a data change that
   // lands in the same sample as an scl edge is not taken for either condition
   assign i2c_start = s_reg.scl_sync[1] & s_reg.scl_sync[2] & ~s_reg.sda_sync[1] & s_reg.sda_sync[2];
   assign i2c_stop  = s_reg.scl_sync[1] & s_reg.scl_sync[2] & s_reg.sda_sync[1] & ~s_reg.sda_sync[2];
   assign ss_fall   = ~s_reg.ss_sync[1] & s_reg.ss_sync[2];
   assign ss_rise   = s_reg.ss_sync[1] & ~s_reg.ss_sync[2];
   assign sclk_rise = scl_rise;
   assign sclk_fall = scl_fall;

   // I2C shares its pins with the density modes; SPI owns them alone
   assign spi_on = (output_sel == SEL_SPI);
   assign i2c_on = (output_sel == SEL_I2C) || (output_sel == SEL_CAP)
                   || (output_sel == SEL_CAPTEMP);

   // unlocked parts answer any address on the bus;
   // the address sits above the direction bit in the received byte
   assign addr_hit = (s_reg.lock_reg != LOCK_ON)
                     || (s_reg.rx_byte[7:1] == s_reg.addr_reg);

   // packet image, taken into the shift register only at transfer start
   assign status = command_mode ? ST_CMD : (s_reg.fresh ? ST_FRESH : ST_STALE);
   assign cap_v  = diag_error ? DIAG_SAT : result.cap;
   assign temp_v = diag_error ? DIAG_SAT : result.temp;
   assign packet = {status, cap_v, temp_v, PAD_BITS};

   // next-state logic for routing, I2C and SPI engines
   always_comb begin
      s_next             = s_reg;
      s_next.scl_sync    = {s_reg.scl_sync[1:0], scl_in};
      s_next.sda_sync    = {s_reg.sda_sync[1:0], sda_in};
      s_next.ss_sync     = {s_reg.ss_sync[1:0], ss_n_in};
      s_next.measure_req = 1'b0;
      s_next.cal_strobe  = 1'b0;
      s_next.fetch_done  = 1'b0;
      s_next.sda_out     = 1'b0;

      // shared pin routing
      s_next.ready_pin     = (output_sel == SEL_CAP || output_sel == SEL_CAPTEMP)
                             ? cap_density_out : ready_in;
      s_next.alarm_low_pin = (output_sel == SEL_CAPTEMP)
                             ? temp_density_out : alarm_low_in;

      // configuration word load; reset leaves factory values in place
      if (cfg_load) begin
         s_next.addr_reg = slave_address_field;
         s_next.lock_reg = addr_lock_field;
      end

      // I2C slave; bit action on synced SCL edges, start and stop on SDA edges, enough for 400 kHz
      if (!i2c_on) begin
         s_next.ist    = I_IDLE;
         s_next.sda_oe = 1'b0;
      end else if (i2c_start) begin
         // the scl fall closing a start finds bit_cnt at zero; the armed
         // flag keeps it from passing for a complete byte
         s_next.ist      = I_ADDR;
         s_next.bit_cnt  = 3'h0;
         s_next.rx_armed = 1'b0;
         s_next.sda_oe   = 1'b0;
      end else if (i2c_stop) begin
         // the read only counts once the bus is released
         if (s_reg.rd_xfer)
            s_next.fetch_done = 1'b1;
         s_next.rd_xfer = 1'b0;
         s_next.ist     = I_IDLE;
         s_next.sda_oe  = 1'b0;
      end else begin
         case (s_reg.ist)
            I_ADDR, I_RX: begin
               if (scl_rise) begin
                  s_next.rx_byte  = {s_reg.rx_byte[6:0], sda_now};
                  s_next.bit_cnt  = s_reg.bit_cnt + 3'h1;
                  s_next.rx_armed = 1'b1;
               end else if (scl_fall && s_reg.bit_cnt == 3'h0 && s_reg.rx_armed) begin
                  // eight bits in: acknowledge or drop out
                  s_next.rx_armed = 1'b0;
                  if (s_reg.ist == I_RX) begin
                     s_next.sda_oe = 1'b1;
                     s_next.ist    = I_RACK;
                     if (command_mode) begin
                        s_next.cal_byte   = s_reg.rx_byte;
                        s_next.cal_strobe = 1'b1;
                     end
                  end else if (addr_hit) begin
                     s_next.sda_oe = 1'b1;
                     s_next.ist    = I_AACK;
                     if (s_reg.rx_byte[0])
                        s_next.tx_shift = packet;
                  end else begin
                     s_next.ist = I_IDLE;
                  end
               end
            end
            I_AACK: begin
               if (scl_fall) begin
                  s_next.bit_cnt = 3'h0;
                  if (s_reg.rx_byte[0]) begin
                     s_next.ist     = I_TX;
                     s_next.rd_xfer = 1'b1;
                     // first data bit one cycle after the fall, inside hold time
                     s_next.sda_oe  = ~s_reg.tx_shift[31];
                  end else begin
                     s_next.ist    = I_RX;
                     s_next.sda_oe = 1'b0;
                     // address plus write wakes a sleeping part
                     if (sleep_mode && !command_mode)
                        s_next.measure_req = 1'b1;
                  end
               end
            end
            I_TX: begin
               if (scl_fall) begin
                  // rotate so a long read wraps instead of sending junk
                  s_next.tx_shift = {s_reg.tx_shift[30:0], s_reg.tx_shift[31]};
                  s_next.bit_cnt  = s_reg.bit_cnt + 3'h1;
                  if (s_reg.bit_cnt == BYTE_LAST) begin
                     s_next.sda_oe = 1'b0;
                     s_next.ist    = I_MACK;
                  end else begin
                     s_next.sda_oe = ~s_reg.tx_shift[30];
                  end
               end
            end
            I_MACK: begin
               if (scl_rise)
                  s_next.mack_ok = ~sda_now;
               else if (scl_fall) begin
                  s_next.bit_cnt = 3'h0;
                  if (s_reg.mack_ok) begin
                     s_next.ist    = I_TX;
                     s_next.sda_oe = ~s_reg.tx_shift[31];
                  end else begin
                     // a nack ends the stream; the stop then counts the fetch
                     s_next.ist = I_IDLE;
                  end
               end
            end
            I_RACK: begin
               if (scl_fall) begin
                  s_next.sda_oe  = 1'b0;
                  s_next.bit_cnt = 3'h0;
                  s_next.ist     = I_RX;
               end
            end
            default: begin
               s_next.ist    = I_IDLE;
               s_next.sda_oe = 1'b0;
            end
         endcase
      end

      // read-only SPI slave; slave select ignored in every other mode
      if (!spi_on) begin
         s_next.miso_oe = 1'b0;
      end else if (ss_fall) begin
         // later results wait here until the next select
         s_next.tx_shift = packet;
         s_next.miso_out = packet[31];
         s_next.miso_oe  = 1'b1;
         s_next.spi_bits = 6'h00;
         s_next.spi_seen = 1'b0;
      end else if (ss_rise) begin
         s_next.miso_oe = 1'b0;
         // a length counts when its bit total modulo 64 is at least one byte; short reads are allowed
         if (s_reg.spi_bits >= SPI_ONE_BYTE)
            s_next.fetch_done = 1'b1;
         // in sleep a read doubles as a measurement request
         if (sleep_mode && s_reg.spi_bits >= SPI_ONE_BYTE)
            s_next.measure_req = 1'b1;
      end else if (!s_reg.ss_sync[1]) begin
         // sample edge counts a bit; shift edge only after a sample edge,
         // so a leading shift edge from either idle level is harmless
         if ((spi_sample_edge ? sclk_fall : sclk_rise)) begin
            s_next.spi_seen = 1'b1;
            s_next.spi_bits = s_reg.spi_bits + 6'h01;
         end else if ((spi_sample_edge ? sclk_rise : sclk_fall) && s_reg.spi_seen) begin
            s_next.tx_shift = {s_reg.tx_shift[30:0], 1'b0};
            s_next.miso_out = s_reg.tx_shift[30];
         end
      end

      // fresh flag: a new result wins over a fetch in the same cycle
      // a result landing mid-frame is cleared by that frame's fetch_done and reads stale next time
      if (s_reg.fetch_done)
         s_next.fresh = 1'b0;
      if (result_valid)
         s_next.fresh = 1'b1;
   end

   // the whole state in one register
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s_reg          <= '0;
         // samplers start at the idle level of every bus pin
         s_reg.scl_sync <= 3'h7;
         s_reg.sda_sync <= 3'h7;
         s_reg.ss_sync  <= 3'h7;
         s_reg.ist      <= I_IDLE;
         s_reg.addr_reg <= FACTORY_ADDR;
         s_reg.lock_reg <= FACTORY_LOCK;
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs come straight from the state register
   assign sda_out       = s_reg.sda_out;
   assign sda_oe        = s_reg.sda_oe;
   assign miso_out      = s_reg.miso_out;
   assign miso_oe       = s_reg.miso_oe;
   assign ready_pin     = s_reg.ready_pin;
   assign alarm_low_pin = s_reg.alarm_low_pin;
   assign measure_req   = s_reg.measure_req;
   assign cal_byte      = s_reg.cal_byte;
   assign cal_strobe    = s_reg.cal_strobe;
   assign fetch_done    = s_reg.fetch_done;

endmodule : sensor_result_output_port

/* File: sim/sensor_port_props.sv */
/* Checker for the result output port: pin routing, miso ownership, pulses.
   Assumes it is bound onto the port's top module and sees its ports only. */
module sensor_port_props
   import sensor_port_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       arst_n,
   input wire logic [2:0] output_sel,
   input wire logic       ss_n_in,
   input wire logic       scl_in,
   input wire logic       sleep_mode,
   input wire logic       command_mode,
   input wire logic       cap_density_out,
   input wire logic       temp_density_out,
   input wire logic       ready_in,
   input wire logic       sda_oe,
   input wire logic       miso_out,
   input wire logic       miso_oe,
   input wire logic       ready_pin,
   input wire logic       alarm_low_pin,
   input wire logic       measure_req,
   input wire logic       cal_strobe
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   // six quiet samples outlast the three-stage pin samplers
   sequence s_ss_idle; ss_n_in [*6]; endsequence
   sequence s_clk_quiet; (miso_oe && $stable(scl_in)) [*6]; endsequence
   a_ready_density: assert property ((output_sel == SEL_CAP || output_sel == SEL_CAPTEMP)
      |=> ready_pin == $past(cap_density_out)) else $error("ready pin lost density");
   a_ready_plain: assert property (output_sel == SEL_I2C |=> ready_pin == $past(ready_in))
      else $error("ready pin not routed");
   a_temp_route: assert property (output_sel == SEL_CAPTEMP |=> alarm_low_pin == $past(temp_density_out))
      else $error("low alarm pin lost temp");
   a_miso_mode: assert property (miso_oe |-> output_sel == SEL_SPI) else $error("miso outside spi");
   a_sda_spi: assert property ((output_sel == SEL_SPI) [*2] |-> !sda_oe) else $error("sda in spi");
   a_miso_release: assert property (s_ss_idle |-> !miso_oe) else $error("miso not released");
   a_miso_hold: assert property (s_clk_quiet |-> $stable(miso_out)) else $error("miso moved");
   a_mreq_sleep: assert property (measure_req |-> sleep_mode ##1 !measure_req)
      else $error("bad measure pulse");
   a_cal_cmd: assert property (cal_strobe |-> command_mode && output_sel == SEL_I2C)
      else $error("cal byte outside command mode");
endmodule : sensor_port_props

/* File: sim/bus_master_model.sv */
/* Bus master model: i2c master on open-drain data, read-only spi master.
   Assumes the bench resolves sda with a pull-up and returns wire levels. */
module bus_master_model (
   output logic      scl,
   output logic      sda_low,
   output logic      ss_n,
   input  wire logic sda_line,
   input  wire logic miso_line
);
   timeunit 1ns;
   timeprecision 1ns;
   int half = 1250; // half period in ns, never above 25 us
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
      ss_n = 1'b1;
   end
   task automatic start_cond();
      sda_low = 1'b1;
      #(half) scl = 1'b0;
   endtask : start_cond
   // data moves mid-low, read mid-high: covers the slave's late sda change
   task automatic xfer_bit(input logic b, output logic r);
      #(half / 2) sda_low = !b;
      #(half / 2) scl = 1'b1;
      #(half / 2) r = sda_line;
      #(half / 2) scl = 1'b0;
   endtask : xfer_bit
   task automatic xfer_byte(input logic [7:0] d, input logic rel, output logic [7:0] q, output logic a);
      for (int i = 7; i >= 0; i--) xfer_bit(d[i], q[i]);
      xfer_bit(rel, a); // ack slot: release, or pull low to go on
   endtask : xfer_byte
   task automatic stop_cond();
      #(half / 2) sda_low = 1'b1;
      #(half / 2) scl = 1'b1;
      #(half / 2) sda_low = 1'b0;
      #(half);
   endtask : stop_cond
   // never drives miso; samples on the chosen edge only
   task automatic spi_read(input int n, input logic pol, input logic smp_fall, output logic [31:0] q);
      int got;
      got = 0;
      q = '0;
      scl = pol;
      #(half) ss_n = 1'b0;
      #(2500);
      while (got < n) begin
         #(half) scl = !scl;
         if (scl == !smp_fall) begin
            q = {q[30:0], miso_line};
            got++;
         end
      end
      #(half) scl = pol;
      #(half) ss_n = 1'b1;
      #(2000);
   endtask : spi_read
endmodule : bus_master_model

/* File: sim/sensor_result_output_port_tb.sv */
/* Bench for the result output port: i2c fetches, address lock, command and
   sleep side effects, spi in all clock forms, pin routing.
   Assumes the package, the checker and the bus master model come first. */
module sensor_result_output_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import sensor_port_pkg::*;
   logic       clk_sys = 1'b0, arst_n = 1'b0, cfg_load = 1'b0, spi_sample_edge = 1'b0;
   logic       sleep_mode = 1'b0, command_mode = 1'b0, diag_error = 1'b0, result_valid = 1'b0;
   logic       ready_in = 1'b1, alarm_low_in = 1'b0, cap_density_out = 1'b0, temp_density_out = 1'b0;
   logic [2:0] output_sel = SEL_I2C, addr_lock_field = 3'h0;
   logic [6:0] slave_address_field = 7'h10;
   result_t    result = {14'h1234, 14'h2d5a};
   wire        scl_in, sda_low, ss_n_in;
   logic       sda_out, sda_oe, miso_out, miso_oe, ready_pin, alarm_low_pin, measure_req, cal_strobe, fetch_done;
   logic [7:0] cal_byte, cal_seen = 8'h00;
   logic       miso_last = 1'b0, a;
   logic [31:0] q;
   logic [2:0] lk_tab [4] = '{3'h0, 3'h2, 3'h7, 3'h3};
   int         fail_count = 0, checks_done = 0, mreq_n = 0, done_n = 0;
   wire        sda_in = !(sda_oe || sda_low); // pull-up on sda
   wire        miso_line = miso_oe ? miso_out : !miso_last; // released line shows no stale bit
   always #25 clk_sys = !clk_sys;
   sensor_result_output_port i_dut (.*);
   bus_master_model i_mc (.scl(scl_in), .sda_low(sda_low), .ss_n(ss_n_in), .sda_line(sda_in),
      .miso_line(miso_line));
   // pulse counters and captures
   always @(posedge clk_sys) begin
      if (measure_req === 1'b1) mreq_n++;
      if (fetch_done === 1'b1) done_n++;
      if (cal_strobe === 1'b1) cal_seen = cal_byte;
      if (miso_oe === 1'b1) miso_last = miso_out;
   end
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : conclude
   // expected packet; the two pad bits are masked by shifting them out
   function automatic logic [31:0] pkt(input logic [1:0] st, input logic [13:0] c, input logic [13:0] t);
      return {st, c, t, 2'h0} >> 2;
   endfunction : pkt
   task automatic cfg(input logic [6:0] ad, input logic [2:0] lk);
      @(posedge clk_sys);
      slave_address_field <= ad;
      addr_lock_field <= lk;
      cfg_load <= 1'b1;
      @(posedge clk_sys);
      cfg_load <= 1'b0;
   endtask : cfg
   task automatic i2c_read(input logic [6:0] ad, input int n, output logic [31:0] d, output logic ack);
      logic [7:0] b;
      logic       s;
      d = '0;
      i_mc.start_cond();
      i_mc.xfer_byte({ad, 1'b1}, 1'b1, b, ack);
      for (int i = 0; i < n && !ack; i++) begin
         i_mc.xfer_byte(8'hff, i == n - 1, b, s);
         d = {d[23:0], b};
      end
      i_mc.stop_cond();
   endtask : i2c_read
   task automatic i2c_write(input logic [6:0] ad, input int n);
      logic [7:0] b;
      i_mc.start_cond();
      i_mc.xfer_byte({ad, 1'b0}, 1'b1, b, a);
      if (n > 0) i_mc.xfer_byte(8'ha5, 1'b1, b, a);
      i_mc.stop_cond();
   endtask : i2c_write
   initial begin
      repeat (16) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (8) @(posedge clk_sys);
      i2c_read(7'h28, 4, q, a);
      check("addr ack", 0, a);
      check("sda level", 0, sda_out);
      check("stale pkt", pkt(ST_STALE, 14'h1234, 14'h2d5a), q >> 2);
      @(posedge clk_sys) result_valid <= 1'b1;
      @(posedge clk_sys) result_valid <= 1'b0;
      i2c_read(7'h28, 4, q, a);
      check("fresh pkt", pkt(ST_FRESH, 14'h1234, 14'h2d5a), q >> 2);
      check("fetch ends", 2, done_n);
      i2c_read(7'h28, 2, q, a);
      check("short pkt", pkt(ST_STALE, 14'h1234, 14'h2d5a) >> 14, q);
      foreach (lk_tab[i]) begin
         cfg(7'h10, lk_tab[i]);
         i2c_read(7'h29, 1, q, a);
         check("lock ack", lk_tab[i] == 3'h3, a);
      end
      i_mc.half = 5000; // slow bus at 100 kHz
      diag_error <= 1'b1;
      i2c_read(7'h10, 4, q, a);
      check("diag pkt", pkt(ST_STALE, 14'h3fff, 14'h3fff), q >> 2);
      i_mc.half = 1250;
      diag_error <= 1'b0;
      command_mode <= 1'b1;
      i2c_read(7'h10, 1, q, a);
      check("cmd status", 2'h2, q[7:6]);
      i2c_write(7'h10, 1);
      check("cal byte", 8'ha5, cal_seen);
      command_mode <= 1'b0;
      sleep_mode <= 1'b1;
      i2c_write(7'h10, 0);
      check("i2c measure", 1, mreq_n);
      sleep_mode <= 1'b0;
      output_sel <= SEL_SPI;
      repeat (4) @(posedge clk_sys);
      for (int m = 0; m < 4; m++) begin
         spi_sample_edge <= m[0];
         fork
            i_mc.spi_read(32, m[1], m[0], q);
            begin
               repeat (300) @(posedge clk_sys);
               result <= {14'h0bad, 14'h1eed};
            end
         join
         check("spi pkt", pkt(ST_STALE, 14'h1234, 14'h2d5a), q >> 2);
         result <= {14'h1234, 14'h2d5a};
      end
      check("miso idle", 0, miso_oe);
      sleep_mode <= 1'b1;
      i_mc.spi_read(16, 1'b1, 1'b1, q);
      check("spi short", pkt(ST_STALE, 14'h1234, 14'h2d5a) >> 14, q);
      check("spi measure", 2, mreq_n);
      sleep_mode <= 1'b0;
      output_sel <= SEL_CAPTEMP;
      cap_density_out <= 1'b1;
      temp_density_out <= 1'b1;
      repeat (3) @(posedge clk_sys);
      check("ready density", 1, ready_pin);
      check("temp density", 1, alarm_low_pin);
      output_sel <= SEL_CAP;
      alarm_low_in <= 1'b1;
      cap_density_out <= 1'b0;
      repeat (3) @(posedge clk_sys);
      check("cap only", 2'h1, {ready_pin, alarm_low_pin});
      conclude();
   end
   initial begin
      #(4000000);
      fail_count++;
      $display("Error run time expected finish seen limit");
      conclude();
   end
endmodule : sensor_result_output_port_tb
bind sensor_result_output_port sensor_port_props i_props (.*);
